// >>> inc/jlsa_regs.svh
// register offsets, field positions and reset values of the alignment block
// assumes an 8-bit register port with 12-bit byte addresses
`ifndef JLSA_REGS_SVH
`define JLSA_REGS_SVH
`define JLSA_ADDR_CAPTURE_CTRL 12'h0120
`define JLSA_ADDR_TIMING_MON 12'h0128
`define JLSA_ADDR_LANE_RATE 12'h056E
`define JLSA_ADDR_PHASE_OFFSET 12'h0578
`define JLSA_ADDR_SUBCLASS 12'h0590
`define JLSA_RST_CAPTURE_CTRL 8'h00
`define JLSA_RST_LANE_RATE 8'h00
`define JLSA_RST_PHASE_OFFSET 8'h00
`define JLSA_RST_SUBCLASS 8'h20
`define JLSA_RST_TIMING_MON 8'h00
`define JLSA_CTRL_MODE_LO 1
`define JLSA_CTRL_MODE_HI 2
`define JLSA_CTRL_CLK_EDGE 3
`define JLSA_CTRL_TRANSITION 4
`define JLSA_SUBCLASS_BIT 5
`define JLSA_OFFSET_HI 4
`define JLSA_MON_MARGIN_BAD 0
`define JLSA_MON_CAPTURED 1
`define JLSA_LANE_RATE_13G 8'h00
`define JLSA_LANE_RATE_6G5 8'h10
`endif

// >>> inc/jlsa_pkg.sv
// types shared by the alignment block
// assumes nothing beyond a SystemVerilog compiler
package jlsa_pkg;
  typedef logic [11:0] jlsa_addr_t;
  typedef logic [7:0] jlsa_byte_t;
  typedef enum logic [1:0] {
    JLSA_SYSREF_OFF,
    JLSA_SYSREF_CONTINUOUS,
    JLSA_SYSREF_ONE_SHOT,
    JLSA_SYSREF_RESERVED
  } jlsa_sysref_mode_t;
endpackage

// >>> hdl/jlsa_align.sv
// multiframe clock generation and system reference alignment
// assumes CLK is the device (converter) clock and SYSREF an unsynced pin
// How it works
// - subclass bit picks class one (reset default) or class zero.
// - class zero runs freely and ignores the system reference pin.
// - each accepted class-one event resets multiframe and sample dividers.
// - multiframe clock pulse marks the first sample of each multiframe.
// - five-bit offset delays the multiframe clock in frame steps.
// - offset scaled by octets per frame: quarter, half or whole.
// - both ends keep total latency spread within one multiframe period.
// - readable monitor reports capture setup/hold margin per event.
// - control bit picks rising or falling reference transition.
// - control bit picks rising or falling clock edge for sampling.
// - lane-rate range register drives the serializer range output.
// - full-bandwidth defaults: 16-bit words, F one, K thirty-two.
// - complex decimate-by-four mode uses four octets per frame.
// - multiframe rate equals clock over samples times frames.
`include "jlsa_regs.svh"
module jlsa_align #(
  parameter int OCTETS_PER_FRAME = 1,
  parameter int SAMPLES_PER_FRAME = 1,
  parameter int FRAMES_PER_MULTI = 32,
  parameter int LANES = 4,
  parameter int CONVERTERS = 2,
  parameter int SAMPLE_BITS = 14,
  parameter int WORD_BITS = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic SYSREF,
  input wire jlsa_pkg::jlsa_addr_t REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire jlsa_pkg::jlsa_byte_t REG_WDATA,
  output jlsa_pkg::jlsa_byte_t REG_RDATA,
  output logic LMFC,
  output logic FRAME_START,
  output logic ALIGNED,
  output logic SUBCLASS1,
  output jlsa_pkg::jlsa_byte_t LANE_RATE
);
  localparam int FW = $clog2(FRAMES_PER_MULTI + 1);
  localparam int SW = $clog2(SAMPLES_PER_FRAME + 1);

  jlsa_pkg::jlsa_byte_t capture_ctrl;
  jlsa_pkg::jlsa_byte_t timing_mon;
  jlsa_pkg::jlsa_byte_t phase_offset;
  jlsa_pkg::jlsa_byte_t subclass_reg;
  logic pos_meta, pos_sync, pos_prev;
  logic neg_cap, neg_meta, neg_sync;
  logic [FW-1:0] frame_cnt;
  logic [SW-1:0] sample_cnt;

  // register decode
  wire wr_ctrl = REG_WR && REG_ADDR == `JLSA_ADDR_CAPTURE_CTRL;
  wire wr_rate = REG_WR && REG_ADDR == `JLSA_ADDR_LANE_RATE;
  wire wr_offs = REG_WR && REG_ADDR == `JLSA_ADDR_PHASE_OFFSET;
  wire wr_subc = REG_WR && REG_ADDR == `JLSA_ADDR_SUBCLASS;
  wire jlsa_pkg::jlsa_byte_t read_mux =
    (REG_ADDR == `JLSA_ADDR_CAPTURE_CTRL) ? capture_ctrl :
    (REG_ADDR == `JLSA_ADDR_TIMING_MON) ? timing_mon :
    (REG_ADDR == `JLSA_ADDR_LANE_RATE) ? LANE_RATE :
    (REG_ADDR == `JLSA_ADDR_PHASE_OFFSET) ? phase_offset :
    (REG_ADDR == `JLSA_ADDR_SUBCLASS) ? subclass_reg : 8'h00;

  wire is_class1 = subclass_reg[`JLSA_SUBCLASS_BIT];
  wire jlsa_pkg::jlsa_sysref_mode_t mode = jlsa_pkg::jlsa_sysref_mode_t'(
    capture_ctrl[`JLSA_CTRL_MODE_HI:`JLSA_CTRL_MODE_LO]);
  wire armed = mode == jlsa_pkg::JLSA_SYSREF_CONTINUOUS ||
    mode == jlsa_pkg::JLSA_SYSREF_ONE_SHOT;

  // level seen through the chosen clock edge
  wire use_neg = capture_ctrl[`JLSA_CTRL_CLK_EDGE];
  wire level_now = use_neg ? neg_sync : pos_sync;
  wire level_old = pos_prev;
  // rising (bit clear) or falling (bit set) transition of the level
  wire fall_sel = capture_ctrl[`JLSA_CTRL_TRANSITION];
  wire edge_seen = fall_sel ? (level_old && !level_now) :
    (level_now && !level_old);
  // reference is ignored in class zero, so an open pin is harmless
  wire accept = edge_seen && armed && is_class1;
  // both edge samples disagree: reference sits near a clock edge
  wire margin_bad = pos_sync != neg_sync;

  // offset in frames, scaled by octets per frame
  wire [4:0] offs = phase_offset[`JLSA_OFFSET_HI:0];
  wire [4:0] shift_frames = (OCTETS_PER_FRAME == 1) ? {2'b00, offs[4:2]} :
    (OCTETS_PER_FRAME == 2) ? {1'b0, offs[4:1]} : offs;
  wire [FW-1:0] shift_mod = FW'(32'(shift_frames) %
    FRAMES_PER_MULTI);

  wire sample_wrap = sample_cnt == SW'(SAMPLES_PER_FRAME - 1);
  wire frame_wrap = frame_cnt == FW'(FRAMES_PER_MULTI - 1);
  // divider chain: samples per frame, then frames per multiframe
  wire [SW-1:0] next_sample_cnt = (accept || sample_wrap) ? '0 :
    sample_cnt + SW'(1);
  wire [FW-1:0] next_frame_cnt = accept ? '0 :
    !sample_wrap ? frame_cnt : frame_wrap ? '0 : frame_cnt + FW'(1);
  wire next_frame_start = next_sample_cnt == '0;
  wire next_lmfc = next_frame_start && next_frame_cnt == shift_mod;

  // in one-shot mode the mode field clears after the accepted event
  wire jlsa_pkg::jlsa_byte_t next_capture_ctrl = wr_ctrl ? REG_WDATA :
    (accept && mode == jlsa_pkg::JLSA_SYSREF_ONE_SHOT) ?
    (capture_ctrl & 8'hF9) : capture_ctrl;
  wire jlsa_pkg::jlsa_byte_t next_timing_mon = accept ?
    {6'b00_0000, 1'b1, margin_bad} : timing_mon;

  // falling-edge capture flop feeding a normal two-stage synchroniser
  always_ff @(negedge CLK or posedge RST) begin
    if (RST) begin
      neg_cap <= 1'b0;
    end else if (CE) begin
      neg_cap <= SYSREF;
    end
  end

  // rising-edge path: two flops before any logic reads the pin
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pos_meta <= 1'b0;
      pos_sync <= 1'b0;
    end else if (CE) begin
      pos_meta <= SYSREF;
      pos_sync <= pos_meta;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      neg_meta <= 1'b0;
      neg_sync <= 1'b0;
    end else if (CE) begin
      neg_meta <= neg_cap;
      neg_sync <= neg_meta;
    end
  end

  // previous level clears to the idle pin level, so reset makes no edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pos_prev <= 1'b0;
    end else if (CE) begin
      pos_prev <= level_now;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      capture_ctrl <= `JLSA_RST_CAPTURE_CTRL;
    end else if (CE) begin
      capture_ctrl <= next_capture_ctrl;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      timing_mon <= `JLSA_RST_TIMING_MON;
    end else if (CE) begin
      timing_mon <= next_timing_mon;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_offset <= `JLSA_RST_PHASE_OFFSET;
    end else if (CE) begin
      if (wr_offs) begin
        phase_offset <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      subclass_reg <= `JLSA_RST_SUBCLASS;
    end else if (CE) begin
      if (wr_subc) begin
        subclass_reg <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LANE_RATE <= `JLSA_RST_LANE_RATE;
    end else if (CE) begin
      if (wr_rate) begin
        LANE_RATE <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else if (CE) begin
      if (REG_RD) begin
        REG_RDATA <= read_mux;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sample_cnt <= '0;
      frame_cnt <= '0;
    end else if (CE) begin
      sample_cnt <= next_sample_cnt;
      frame_cnt <= next_frame_cnt;
    end
  end

  // fixed local boundary lets the receiver bound the latency spread
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LMFC <= 1'b0;
      FRAME_START <= 1'b0;
    end else if (CE) begin
      LMFC <= next_lmfc;
      FRAME_START <= next_frame_start;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ALIGNED <= 1'b0;
      SUBCLASS1 <= 1'b1;
    end else if (CE) begin
      SUBCLASS1 <= is_class1;
      if (!is_class1) begin
        ALIGNED <= 1'b0;
      end else if (accept) begin
        ALIGNED <= 1'b1;
      end
    end
  end
endmodule // jlsa_align

// >>> testbench/jlsa_align_properties.sv
// port assertions for the alignment block
// assumes bind into jlsa_align, one clock, RST async high
module jlsa_align_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire jlsa_pkg::jlsa_addr_t REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire jlsa_pkg::jlsa_byte_t REG_WDATA,
  input wire jlsa_pkg::jlsa_byte_t REG_RDATA,
  input wire logic LMFC,
  input wire logic FRAME_START,
  input wire logic ALIGNED,
  input wire logic SUBCLASS1,
  input wire jlsa_pkg::jlsa_byte_t LANE_RATE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire ws = REG_WR && REG_ADDR == 12'h0590;
  wire wl = REG_WR && REG_ADDR == 12'h056E;
  AST_SUB_COPY: assert property (ws ##1 !ws |=>
    SUBCLASS1 == $past(REG_WDATA[5], 2)) else $error("subclass copy");
  AST_LR_REG: assert property (wl |=>
    LANE_RATE == $past(REG_WDATA)) else $error("lane rate write");
  AST_LR_HOLD: assert property (!wl |=> $stable(LANE_RATE))
    else $error("lane rate moved");
  AST_LR_READ: assert property (REG_RD && !REG_WR && REG_ADDR ==
    12'h056E |=> REG_RDATA == $past(LANE_RATE)) else $error("rate read");
  AST_RD_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
  AST_CLASS0: assert property (!SUBCLASS1 && $past(!SUBCLASS1)
    |-> !ALIGNED) else $error("aligned in class zero");
  AST_ALIGN_HOLD: assert property (ALIGNED && !ws && !$past(ws)
    |=> ALIGNED) else $error("alignment lost");
  AST_LMFC_FRAME: assert property (LMFC |-> FRAME_START)
    else $error("multiframe off frame");
  AST_LMFC_PULSE: assert property (LMFC |=> !LMFC)
    else $error("doubled multiframe");
  cover property ($rose(ALIGNED));
  cover property (LMFC && ALIGNED);
  cover property (ws ##2 !SUBCLASS1);
endmodule // jlsa_align_properties
bind jlsa_align jlsa_align_properties chk_u (.CLK, .RST, .REG_ADDR,
  .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .LMFC, .FRAME_START,
  .ALIGNED, .SUBCLASS1, .LANE_RATE);

// >>> testbench/jlsa_rx_model.sv
// far end: reference source and multiframe period watcher
// assumes CLK shared with the device, fire pulsed by the bench
module jlsa_rx_model (
  input wire logic CLK,
  input wire logic RST,
  input wire logic LMFC,
  input wire logic fire,
  output logic SYSREF,
  output logic [7:0] gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] hold = 3'h0;
  logic [7:0] cnt;
  assign SYSREF = hold != 3'h0;
  // six-cycle pulse, above the two-cycle minimum
  always @(negedge CLK) begin
    if (fire)
      hold <= 3'h6;
    else if (SYSREF)
      hold <= hold - 3'h1;
  end
  // period counted between the device's multiframe pulses
  always @(posedge CLK) begin
    cnt <= (RST || LMFC) ? 8'h01 : cnt + 8'h01;
    if (LMFC)
      gap <= cnt;
  end
endmodule // jlsa_rx_model

// >>> testbench/jlsa_align_tb.sv
// bench: register walk and reference alignment timing
// assumes the far-end model drives the reference pin, CE held high
module jlsa_align_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0, fire = 0;
  logic LMFC, FRAME_START, ALIGNED, SUBCLASS1, SYSREF;
  jlsa_pkg::jlsa_addr_t REG_ADDR = 12'h0000;
  jlsa_pkg::jlsa_byte_t REG_WDATA = 8'h00, REG_RDATA, LANE_RATE, gap;
  int fail_count = 0, n_compared = 0, cyc = 0, d0, d, k;
  jlsa_align dut_u (.CLK, .RST, .CE(1'b1), .SYSREF, .REG_ADDR, .REG_WR,
    .REG_RD, .REG_WDATA, .REG_RDATA, .LMFC, .FRAME_START, .ALIGNED,
    .SUBCLASS1, .LANE_RATE);
  jlsa_rx_model far_u (.CLK, .RST, .LMFC, .fire, .SYSREF, .gap);
  initial forever #4 CLK = ~CLK;
  task end_of_test;
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input jlsa_pkg::jlsa_addr_t a, input jlsa_pkg::jlsa_byte_t w);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = w;
    REG_WR = 1;
    @(negedge CLK);
    REG_WR = 0;
  endtask
  task rc(input jlsa_pkg::jlsa_addr_t a, input logic [7:0] e, m);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1;
    @(negedge CLK);
    REG_RD = 0;
    chk("rdata", e, REG_RDATA & m);
  endtask
  task lm(output int n);
    n = 0;
    do begin
      @(negedge CLK);
      n++;
    end while (LMFC !== 1'b1 && n < 99);
  endtask
  // fire just after a boundary, count cycles to the next one
  task sync(output int n);
    lm(k);
    fire <= 1'b1;
    @(negedge CLK);
    fire <= 1'b0;
    lm(n);
    n++;
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    @(negedge CLK) RST = 0;
    rc(12'h0120, 8'h00, 8'hFF);
    rc(12'h0128, 8'h00, 8'hFF);
    rc(12'h0578, 8'h00, 8'hFF);
    rc(12'h0590, 8'h20, 8'hFF);
    rc(12'h0100, 8'h00, 8'hFF);
    wr(12'h056E, 8'h10);
    rc(12'h056E, 8'h10, 8'hFF);
    chk("lane_rate", 8'h10, LANE_RATE);
    wr(12'h0120, 8'h02);
    sync(d0);
    chk("aligned", 8'h01, {7'h0, ALIGNED});
    chk("delay", 8'h01, 8'(d0 < 8));
    lm(k);
    @(negedge CLK);
    chk("period", 8'h20, gap);
    wr(12'h0128, 8'hFF);
    rc(12'h0128, 8'h02, 8'hFE);
    wr(12'h0578, 8'h03);
    sync(d);
    chk("off3", 8'(d0), 8'(d));
    wr(12'h0578, 8'h08);
    sync(d);
    chk("off8", 8'(d0 + 2), 8'(d));
    wr(12'h0578, 8'h1F);
    sync(d);
    chk("off31", 8'(d0 + 7), 8'(d));
    wr(12'h0578, 8'h00);
    wr(12'h0120, 8'h12);
    sync(d);
    chk("fall_event", 8'(d0 + 6), 8'(d));
    wr(12'h0120, 8'h0A);
    sync(d);
    chk("fall_clock", 8'(d0 + 1), 8'(d));
    wr(12'h0120, 8'h04);
    sync(d);
    chk("one_shot", 8'(d0), 8'(d));
    rc(12'h0120, 8'h00, 8'hFF);
    sync(d);
    chk("ignored", 8'h01, 8'(d > 8));
    wr(12'h0590, 8'h00);
    wr(12'h0120, 8'h02);
    chk("class0", 8'h00, {7'h0, SUBCLASS1 | ALIGNED});
    sync(d);
    chk("class0_free", 8'h01, 8'(d > 8));
    end_of_test;
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      end_of_test;
    end
  end
endmodule // jlsa_align_tb
